/* bench/bus_host.sv */
/*
 * model of the host processor on the strobe bus.
 * assumes the clock of the block.
 */
`timescale 1ns/100ps
module bus_host (
	// clock and read data
	input wire logic i_clk,
	input wire logic [7:0] i_data,
	// bus pins
	output logic o_rd_n = 1'b1,
	output logic o_wr_n = 1'b1,
	output logic o_ce_n = 1'b1,
	output logic o_chan_a = 1'b1,
	output logic o_d_c = 1'b1,
	output logic [7:0] o_data
);
	logic drv = 1'b0;
	logic [7:0] wd = 8'h00;
	logic [7:0] pat = 8'h5a;
	// released data pins change every cycle
	always @(posedge i_clk) pat <= ~pat;
	assign o_data = drv ? wd : pat;
	// one access: strobe low six cycles, then high
	task automatic acc(input logic c, rd, dc, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge i_clk);
		o_chan_a <= c;
		o_d_c <= dc;
		o_ce_n <= 1'b0;
		wd <= d;
		drv <= !rd;
		o_rd_n <= !rd;
		o_wr_n <= rd;
		repeat (6) @(posedge i_clk);
		q = i_data;
		o_rd_n <= 1'b1;
		o_wr_n <= 1'b1;
		o_ce_n <= 1'b1;
		drv <= 1'b0;
		// five more edges so registered results have settled on return
		repeat (5) @(posedge i_clk);
	endtask
	// both strobes low for n cycles, chip enable high
	task automatic hw(input int n);
		@(posedge i_clk);
		o_rd_n <= 1'b0;
		o_wr_n <= 1'b0;
		repeat (n) @(posedge i_clk);
		o_rd_n <= 1'b1;
		o_wr_n <= 1'b1;
		repeat (16) @(posedge i_clk);
	endtask
endmodule

/* bench/regbank_props.sv */
/*
 * checker of the register pointer and reset block.
 * assumes a bind onto the top module and one clock.
 */
`timescale 1ns/100ps
module regbank_props
	import regbank_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// bus pins
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic i_ce_n,
	input wire logic i_chan_a,
	input wire logic i_d_c,
	input wire logic [7:0] i_data,
	// outputs watched
	input wire logic [7:0] o_data,
	input wire logic o_data_oe,
	input wire logic o_device_reset,
	input wire logic o_hardware_reset,
	input wire logic [1:0] o_channel_reset,
	input wire channel_ctrl_type o_chan_ctrl_a,
	input wire channel_ctrl_type o_chan_ctrl_b,
	input wire logic [7:0] o_master_control
);
	// both strobes low at the pins
	wire both_low = !i_rd_n && !i_wr_n;
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	hw_enter_a:
		assert property (both_low [*3] |-> ##[0:3] o_hardware_reset)
			else $error("hardware reset not raised");
	hw_hold_a:
		assert property (both_low [*5] |-> o_hardware_reset)
			else $error("hardware reset dropped while held");
	hw_stretch_a:
		assert property ($fell(o_hardware_reset) |-> o_device_reset [*4])
			else $error("hardware reset stretch too short");
	hw_covers_a:
		assert property (o_hardware_reset [*2] |-> o_device_reset)
			else $error("device reset low in hardware reset");
	chan_stretch_a:
		assert property ($rose(o_channel_reset[1]) |-> o_channel_reset[1] [*4])
			else $error("channel reset stretch too short");
	frame_bit7_a:
		assert property (!o_chan_ctrl_a.frame_enhancement[7] &&
			!o_chan_ctrl_b.frame_enhancement[7]) else $error("frame bit 7 set");
	master_cmd_a:
		assert property (o_master_control[7:6] == 2'h0)
			else $error("command bits stored");
	hw_clear_a:
		assert property (o_hardware_reset [*2] |-> o_master_control == 8'h00)
			else $error("master bits kept in hardware reset");
	chan_clear_a:
		assert property (o_channel_reset[1] [*2] |->
			o_chan_ctrl_a.frame_enhancement == 8'h00) else $error("frame kept");
	read_drive_a:
		assert property (o_data_oe |-> !$past(i_rd_n, 3) || !$past(i_rd_n, 4))
			else $error("data driven without read");
endmodule

bind register_pointer_and_reset regbank_props chk_u (.i_clk, .i_reset_n,
	.i_rd_n, .i_wr_n, .i_ce_n, .i_chan_a, .i_d_c, .i_data, .o_data,
	.o_data_oe, .o_device_reset, .o_hardware_reset, .o_channel_reset,
	.o_chan_ctrl_a, .o_chan_ctrl_b, .o_master_control);

/* bench/register_pointer_and_reset_tb.sv */
/*
 * self-checking bench of the register pointer and reset block.
 * assumes the host model and the checker compiled before it.
 */
`timescale 1ns/100ps
module register_pointer_and_reset_tb;
	import regbank_pkg::*;
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic i_rd_n, i_wr_n, i_ce_n, i_chan_a, i_d_c, o_data_oe;
	logic o_device_reset, o_hardware_reset;
	logic [7:0] i_data, o_data, o_master_control, q, v, e;
	logic [1:0] o_channel_reset;
	logic [7:0] wi [4] = '{8'h04, 8'h05, 8'h03, 8'h0a};
	logic [7:0] ri [4] = '{8'h04, 8'h05, 8'h09, 8'h0b};
	channel_ctrl_type o_chan_ctrl_a, o_chan_ctrl_b;
	int num_errors = 0;
	int checks = 0;
	int cyc = 0;
	int dev_cnt = 0;
	int hw_cnt = 0;
	int oe_cnt = 0;
	int cha_cnt = 0;
	int chb_cnt = 0;
	always #20 i_clk = ~i_clk;
	// ------------------------------------------------------------
	// block and host
	// ------------------------------------------------------------
	register_pointer_and_reset dut_u (.i_clk, .i_reset_n, .i_rd_n,
		.i_wr_n, .i_ce_n, .i_chan_a, .i_d_c, .i_data, .o_data, .o_data_oe,
		.o_device_reset, .o_hardware_reset, .o_channel_reset,
		.o_chan_ctrl_a, .o_chan_ctrl_b, .o_master_control);
	bus_host host_u (.i_clk, .i_data(o_data), .o_rd_n(i_rd_n),
		.o_wr_n(i_wr_n), .o_ce_n(i_ce_n), .o_chan_a(i_chan_a),
		.o_d_c(i_d_c), .o_data(i_data));
	// reset cycle counts and run limit
	always @(posedge i_clk) begin
		cyc++;
		dev_cnt += o_device_reset;
		hw_cnt += o_hardware_reset;
		oe_cnt += o_data_oe;
		cha_cnt += o_channel_reset[1];
		chb_cnt += o_channel_reset[0];
		if (cyc > 30000) begin
			num_errors++;
			complete_run();
		end
	end
	task automatic complete_run();
		if (num_errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] x, y);
		checks++;
		if (y !== x) begin
			$display("[ERR] %s expected %h seen %h", n, x, y);
			num_errors++;
		end
	endtask
	task automatic w(input logic c, input logic [7:0] a, d);
		host_u.acc(c, 1'b0, 1'b0, a, q);
		host_u.acc(c, 1'b0, 1'b0, d, q);
	endtask
	task automatic r(input logic c, input logic [7:0] a);
		host_u.acc(c, 1'b0, 1'b0, a, q);
		host_u.acc(c, 1'b1, 1'b0, 8'h00, q);
	endtask
	// frame field of channel A after a command of kind k
	function automatic logic [7:0] frame_of(input logic [1:0] k,
		input logic [7:0] d);
		return k[1] ? 8'h00 : d & 8'h7f;
	endfunction
	// main sequence
	initial begin
		void'($urandom(52567));
		repeat (16) @(posedge i_clk);
		i_reset_n <= 1'b1;
		repeat (4) @(posedge i_clk);
		host_u.acc(1'b1, 1'b1, 1'b0, 8'h00, q);
		w(1'b1, 8'h0f, 8'h05);
		for (int i = 0; i < 3; i++) begin
			v = (i == 0) ? 8'hff : $urandom;
			w(1'b1, 8'h07, v);
			chk("frame_a", frame_of(2'h0, v), o_chan_ctrl_a[8:1]);
			r(1'b1, 8'h0e);
			chk("slot_14", frame_of(2'h0, v), q);
		end
		for (int i = 0; i < 4; i++) begin
			v = $urandom;
			w(1'b1, wi[i], v);
			oe_cnt = 0;
			r(1'b1, ri[i]);
			chk("ext_read", v, q);
			chk("data_oe", 8'h01, {7'h0, oe_cnt > 0});
		end
		chk("map_a", 8'h01, {7'h0, o_chan_ctrl_a.extended_map});
		chk("map_b", 8'h00, {7'h0, o_chan_ctrl_b.extended_map});
		w(1'b0, 8'h04, 8'h3c);
		r(1'b0, 8'h04);
		chk("slot_4_b", 8'h00, q);
		for (int k = 1; k < 4; k++) begin
			v = $urandom;
			e = $urandom;
			w(1'b1, 8'h0f, 8'h05);
			w(1'b1, 8'h07, v);
			w(1'b0, 8'h0f, 8'h05);
			w(1'b0, 8'h07, v);
			dev_cnt = 0;
			hw_cnt = 0;
			cha_cnt = 0;
			chb_cnt = 0;
			w(1'b1, 8'h09, {k[1:0], e[5:0]});
			repeat (12) @(posedge i_clk);
			chk("frame_sw", frame_of(k[1:0], v), o_chan_ctrl_a[8:1]);
			// channel B is cleared by codes with bit 0 set
			chk("frame_b", frame_of({k[0], 1'b0}, v), o_chan_ctrl_b[8:1]);
			chk("chan_a_rst", 8'h01, {7'h0, (k == 2) == (cha_cnt >= 4)});
			chk("chan_b_rst", 8'h01, {7'h0, (k == 1) == (chb_cnt >= 4)});
			chk("master", {2'h0, e[5:0]}, o_master_control);
			chk("hw_sw", 8'h00, hw_cnt[7:0]);
			chk("dev_sw", 8'h01, {7'h0, (k == 3) == (dev_cnt >= 4)});
		end
		dev_cnt = 0;
		hw_cnt = 0;
		oe_cnt = 0;
		host_u.hw(6);
		chk("oe_hw", 8'h00, oe_cnt[7:0]);
		chk("hw_len", 8'h01, {7'h0, hw_cnt >= 6});
		chk("dev_len", 8'h01, {7'h0, dev_cnt >= hw_cnt + 4 &&
			dev_cnt <= hw_cnt + 5});
		chk("master_hw", 8'h00, o_master_control);
		w(1'b1, 8'h0f, 8'h05);
		host_u.acc(1'b1, 1'b0, 1'b0, 8'h07, q);
		host_u.acc(1'b1, 1'b1, 1'b0, 8'h00, q);
		w(1'b1, 8'h07, 8'h2a);
		chk("ptr_clear", 8'h2a, o_chan_ctrl_a[8:1]);
		complete_run();
	end
endmodule

/* rtl/regbank_params.svh */
/*
 * constants of the register pointer and reset block: field positions,
 * register indices, reset values and reset stretch timing.
 * assumes inclusion by bare name from rtl/.
 */
`ifndef REGBANK_PARAMS_SVH
`define REGBANK_PARAMS_SVH

// --------------------------------------------------------------
// register indices seen through the pointer
// --------------------------------------------------------------
`define IDX_COMMAND 4'h0
`define IDX_RECEIVE_CONTROL 4'h3
`define IDX_MODE_CONTROL 4'h4
`define IDX_TRANSMIT_CONTROL 4'h5
`define IDX_FRAME_SLOT 4'h7
`define IDX_MASTER_CONTROL 4'h9
`define IDX_MISC_CONTROL 4'ha
`define IDX_UPPER_SLOT_11 4'hb
`define IDX_UPPER_SLOT_14 4'he
`define IDX_EXT_STATUS_CONTROL 4'hf
`define IDX_SHARED_VECTOR 4'h2

// --------------------------------------------------------------
// field positions
// --------------------------------------------------------------
`define PTR_MSB 2
`define POINT_HIGH_LSB 3
`define POINT_HIGH_CODE 3'h1
`define EXT_ENABLE_BIT 0
`define EXT_MAP_BIT 2
`define FRAME_WRITE_MASK 8'h7f
`define MASTER_KEEP_MASK 8'h3f
`define MASTER_CMD_LSB 6
`define CMD_CHAN_B 2'h1
`define CMD_CHAN_A 2'h2
`define CMD_DEVICE 2'h3

// --------------------------------------------------------------
// reset values
// --------------------------------------------------------------
`define EXT_STATUS_RESET 8'hf8
`define FRAME_RESET 8'h00
`define MASTER_RESET 8'h00

// --------------------------------------------------------------
// reset stretch, in peripheral clock cycles (one clock = 40 ns)
// --------------------------------------------------------------
`define STRETCH_CYCLES 3'h4

`endif

/* rtl/regbank_pkg.sv */
/*
 * types of the register pointer and reset block.
 * assumes nothing of its surroundings.
 */
package regbank_pkg;

	// bus pins as sampled through the synchroniser
	typedef struct packed {
		logic rd_n;
		logic wr_n;
		logic ce_n;
		logic chan_a;
		logic d_c;
		logic [7:0] data;
	} bus_pins_type;

	// per channel control seen by the protocol engines
	typedef struct packed {
		logic [7:0] frame_enhancement;
		logic extended_map;
	} channel_ctrl_type;

	// kind of reset in progress
	typedef enum logic [1:0] {
		RESET_NONE,
		RESET_CHAN_B,
		RESET_CHAN_A,
		RESET_DEVICE
	} reset_kind_type;

endpackage

/* rtl/register_pointer_and_reset.sv */
/*
 * host side register access and reset control of a two channel serial
 * controller: pointer, extended read map, frame enhancement register,
 * hardware and software resets with stretching.
 * assumes asynchronous bus pins from a processor, one 25 MHz clock used
 * as the peripheral clock, and protocol engines reading the outputs.
 */
`timescale 1ns/100ps
`include "regbank_params.svh"

// Notes on behaviour
// - frame enhancement bits 0..6 as listed; bit 7 always stored zero
// - extended map only while ext status bits 0 and 2 are both set
// - extended reads: slots 4,5 mode/transmit; 9,11,14 rx, misc, frame
// - both strobes low means hardware reset, chip enable ignored
// - reset held for as long as both strobes stay low
// - after release reset stretched four to five clocks, accesses ignored
// - hardware reset leaves receive data untouched
// - master control decodes channel A, channel B and full device reset
// - software reset also stretched four to five clocks
// - read with data/command low clears the pointers
// - other master control bits change only on a master control write or a hardware reset
module register_pointer_and_reset
	import regbank_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// processor bus pins
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic i_ce_n,
	input wire logic i_chan_a,
	input wire logic i_d_c,
	input wire logic [7:0] i_data,
	// read data drive
	output logic [7:0] o_data,
	output logic o_data_oe,
	// reset outputs to the engines
	output logic o_device_reset,
	output logic o_hardware_reset,
	output logic [1:0] o_channel_reset,
	// per channel control, index 1 is channel A
	output channel_ctrl_type o_chan_ctrl_a,
	output channel_ctrl_type o_chan_ctrl_b,
	output logic [7:0] o_master_control
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	bus_pins_type pins_meta;
	bus_pins_type pins;
	logic rd_prev;
	logic wr_prev;
	logic [7:0] wdata;
	logic wchan;
	logic wce_n;
	logic wd_c;
	logic [2:0] ptr;
	logic point_high;
	logic [7:0] ext_status [0:1];
	logic [7:0] frame_enh [0:1];
	logic [7:0] master;
	logic [31:0] written;
	logic [2:0] stretch;
	reset_kind_type reset_kind;
	logic [7:0] mem_rdata;
	logic rd_from_mem;
	logic rd_from_frame;
	logic rd_written;
	logic rd_chan;

	// pack one register address from channel and index
	function automatic logic [4:0] reg_addr(input logic chan,
		input logic [3:0] idx);
		logic shared;
		shared = (idx == `IDX_SHARED_VECTOR) ||
			(idx == `IDX_MASTER_CONTROL);
		reg_addr = {chan & ~shared, idx};
	endfunction

	// extended map test for one ext status value
	function automatic logic ext_on(input logic [7:0] esc);
		ext_on = esc[`EXT_ENABLE_BIT] & esc[`EXT_MAP_BIT];
	endfunction

	// ------------------------------------------------------------
	// pin synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		pins_meta <= {i_rd_n, i_wr_n, i_ce_n, i_chan_a, i_d_c, i_data};
		pins <= pins_meta;
	end

	// ------------------------------------------------------------
	// strobe decode
	// ------------------------------------------------------------
	wire hw_now = ~pins.rd_n & ~pins.wr_n;
	wire hw_prev = ~rd_prev & ~wr_prev;
	wire busy = hw_now | hw_prev | (stretch != 3'h0);
	wire wr_end = ~wr_prev & pins.wr_n & rd_prev & ~busy & ~wce_n;
	wire rd_end = ~rd_prev & pins.rd_n & wr_prev & ~busy & ~wce_n;
	wire [3:0] idx = {point_high, ptr};
	wire [4:0] waddr = reg_addr(wchan, idx);
	wire cmd_write = wr_end & ~wd_c;
	wire [1:0] sw_cmd = wdata[7:`MASTER_CMD_LSB];
	wire sw_reset = cmd_write && (idx == `IDX_MASTER_CONTROL) &&
		(sw_cmd != 2'h0);
	wire frame_w = cmd_write && (idx == `IDX_FRAME_SLOT) &&
		ext_status[wchan][`EXT_ENABLE_BIT];
	wire dev_reset = hw_now | (reset_kind == RESET_DEVICE);

	// ------------------------------------------------------------
	// read slot select, extended map only
	// ------------------------------------------------------------
	wire cur_chan = pins.chan_a;
	wire ext_r = ext_on(ext_status[cur_chan]);
	wire [3:0] src_idx = (idx == `IDX_MASTER_CONTROL) ?
		`IDX_RECEIVE_CONTROL :
		(idx == `IDX_UPPER_SLOT_11) ? `IDX_MISC_CONTROL : idx;
	wire [4:0] raddr = reg_addr(cur_chan, src_idx);
	wire mem_slot = ext_r && ((idx == `IDX_MODE_CONTROL) ||
		(idx == `IDX_TRANSMIT_CONTROL) ||
		(idx == `IDX_MASTER_CONTROL) ||
		(idx == `IDX_UPPER_SLOT_11));
	wire frame_slot = ext_r && (idx == `IDX_UPPER_SLOT_14);
	wire [7:0] next_data = rd_from_frame ? frame_enh[rd_chan] :
		(rd_from_mem && rd_written) ? mem_rdata : 8'h00;
	wire next_oe = ~pins.rd_n & ~pins.ce_n & pins.wr_n & ~busy &
		~pins.d_c;

	write_reg_store store (
		.i_clk(i_clk),
		.i_we(cmd_write),
		.i_waddr(waddr),
		.i_wdata(wdata),
		.i_raddr(raddr),
		.o_rdata(mem_rdata)
	);

	// ------------------------------------------------------------
	// access capture while a strobe is low
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			rd_prev <= 1'b1;
			wr_prev <= 1'b1;
			wdata <= 8'h00;
			wchan <= 1'b0;
			wce_n <= 1'b1;
			wd_c <= 1'b1;
		end else begin
			rd_prev <= pins.rd_n;
			wr_prev <= pins.wr_n;
			if (!pins.rd_n || !pins.wr_n) begin
				wdata <= pins.data;
				wchan <= pins.chan_a;
				wce_n <= pins.ce_n;
				wd_c <= pins.d_c;
			end
		end
	end

	// ------------------------------------------------------------
	// reset stretch counter and kind
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			stretch <= 3'h0;
			reset_kind <= RESET_NONE;
		end else if (hw_now) begin
			stretch <= `STRETCH_CYCLES;
			reset_kind <= RESET_DEVICE;
		end else if (sw_reset) begin
			stretch <= `STRETCH_CYCLES;
			case (sw_cmd)
				`CMD_CHAN_A: reset_kind <= RESET_CHAN_A;
				`CMD_CHAN_B: reset_kind <= RESET_CHAN_B;
				default: reset_kind <= RESET_DEVICE;
			endcase
		end else if (stretch != 3'h0) begin
			stretch <= stretch - 3'h1;
		end else begin
			reset_kind <= RESET_NONE;
		end
	end

	// ------------------------------------------------------------
	// pointer
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || dev_reset) begin
			ptr <= 3'h0;
			point_high <= 1'b0;
		end else if (cmd_write && idx == `IDX_COMMAND) begin
			ptr <= wdata[`PTR_MSB:0];
			point_high <= (wdata[5:`POINT_HIGH_LSB] ==
				`POINT_HIGH_CODE);
		end else if (cmd_write || (rd_end && ~wd_c)) begin
			ptr <= 3'h0;
			point_high <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// per channel control registers
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || dev_reset) begin
			ext_status[0] <= `EXT_STATUS_RESET;
			ext_status[1] <= `EXT_STATUS_RESET;
			frame_enh[0] <= `FRAME_RESET;
			frame_enh[1] <= `FRAME_RESET;
		end else begin
			if (cmd_write && idx == `IDX_EXT_STATUS_CONTROL) begin
				ext_status[wchan] <= wdata;
			end
			if (frame_w) begin
				frame_enh[wchan] <= wdata & `FRAME_WRITE_MASK;
			end
			if (reset_kind == RESET_CHAN_A) begin
				frame_enh[1] <= `FRAME_RESET;
			end
			if (reset_kind == RESET_CHAN_B) begin
				frame_enh[0] <= `FRAME_RESET;
			end
		end
	end

	// ------------------------------------------------------------
	// master control keeps its bits through software resets
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || hw_now) begin
			master <= `MASTER_RESET;
		end else if (cmd_write && idx == `IDX_MASTER_CONTROL) begin
			master <= wdata & `MASTER_KEEP_MASK;
		end
	end

	// ------------------------------------------------------------
	// written flags; reset forgets stored write registers
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || dev_reset) begin
			written <= 32'h0;
		end else begin
			if (reset_kind == RESET_CHAN_A) begin
				written[31:16] <= 16'h0;
			end
			if (reset_kind == RESET_CHAN_B) begin
				written[15:0] <= 16'h0;
			end
			if (cmd_write && !frame_w) begin
				written[waddr] <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// read pipeline and outputs
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_reset_n) begin
			rd_from_mem <= 1'b0;
			rd_from_frame <= 1'b0;
			rd_written <= 1'b0;
			rd_chan <= 1'b0;
			o_data <= 8'h00;
			o_data_oe <= 1'b0;
			o_device_reset <= 1'b0;
			o_hardware_reset <= 1'b0;
			o_channel_reset <= 2'h0;
			o_chan_ctrl_a <= '0;
			o_chan_ctrl_b <= '0;
			o_master_control <= 8'h00;
		end else begin
			rd_from_mem <= mem_slot;
			rd_from_frame <= frame_slot;
			rd_written <= written[raddr];
			rd_chan <= cur_chan;
			o_data <= next_data;
			o_data_oe <= next_oe;
			// receive data path is not driven by any reset here
			o_device_reset <= dev_reset;
			o_hardware_reset <= hw_now | hw_prev;
			o_channel_reset <= {reset_kind == RESET_CHAN_A,
				reset_kind == RESET_CHAN_B};
			o_chan_ctrl_a <= {frame_enh[1], ext_on(ext_status[1])};
			o_chan_ctrl_b <= {frame_enh[0], ext_on(ext_status[0])};
			o_master_control <= master;
		end
	end

endmodule

/* rtl/write_reg_store.sv */
/*
 * storage of the write registers of both channels, 32 words of 8 bits,
 * with registered read data.
 * assumes one clock; contents are undefined until written.
 */
`timescale 1ns/100ps
module write_reg_store (
	// clock
	input wire logic i_clk,
	// write side
	input wire logic i_we,
	input wire logic [4:0] i_waddr,
	input wire logic [7:0] i_wdata,
	// read side
	input wire logic [4:0] i_raddr,
	output logic [7:0] o_rdata
);

	logic [7:0] mem [0:31];

	// write port and registered read
	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
		o_rdata <= mem[i_raddr];
	end

endmodule
